// [core/cswk_pkg.sv]
// cswk_pkg: register map, field positions and reset values of the
// selective wake configuration block.
// assumes: 7-bit register addresses and 16-bit register data.
package cswk_pkg;

    localparam logic [6:0]  CSWK_ADDR_CTRL  = 7'h30;
    localparam logic [6:0]  CSWK_ADDR_BTIM  = 7'h31;
    localparam logic [6:0]  CSWK_ADDR_IDH   = 7'h32;
    localparam logic [6:0]  CSWK_ADDR_IDL   = 7'h33;
    localparam logic [6:0]  CSWK_ADDR_MSKH  = 7'h34;
    localparam logic [6:0]  CSWK_ADDR_MSKL  = 7'h35;

    localparam logic [15:0] CSWK_CTRL_RST   = 16'h0000;
    localparam logic [15:0] CSWK_BTIM_RST   = 16'hCC96;
    localparam logic [15:0] CSWK_IDH_RST    = 16'h0000;
    localparam logic [15:0] CSWK_IDL_RST    = 16'h0000;
    localparam logic [15:0] CSWK_MSKH_RST   = 16'h0000;
    localparam logic [15:0] CSWK_MSKL_RST   = 16'h0000;

    // writable bits; also the bits that survive a restart
    localparam logic [15:0] CSWK_CTRL_WMASK = 16'h00F0;
    localparam logic [15:0] CSWK_BTIM_WMASK = 16'hFCFF;
    localparam logic [15:0] CSWK_IDL_WMASK  = 16'hFF7F;
    localparam logic [15:0] CSWK_MSKL_WMASK = 16'hFF7C;

    localparam int          CSWK_VALID_BIT  = 0;
    localparam int          CSWK_TOMASK_BIT = 4;
    localparam int          CSWK_TRIM_LSB   = 5;
    localparam int          CSWK_OSC_BIT    = 7;
    localparam logic [1:0]  CSWK_TRIM_OPEN  = 2'h3;

    localparam int          CSWK_SP_LSB     = 10;
    localparam int          CSWK_QPB_LSB    = 0;
    localparam int          CSWK_IDE_BIT    = 0;
    localparam int          CSWK_RTR_BIT    = 1;
    localparam int          CSWK_STD_LSB    = 18;

endpackage

// [core/cswk_cfg_if.sv]
// cswk_cfg_if: configuration handed from the register file to the
// frame comparator, and the comparator's wake answer.
// assumes: both ends run on the same clock.
`timescale 1ns/100ps
interface cswk_cfg_if;
    logic [28:0] ident;
    logic [28:0] ident_cmp;
    logic        rtr;
    logic        ide;
    logic        enable;
    logic        match;

    modport cfg (output ident, ident_cmp, rtr, ide, enable, input match);
    modport cmp (input ident, ident_cmp, rtr, ide, enable, output match);
endinterface

// [core/cswk_match.sv]
// cswk_match: compares a received CAN frame against the stored wake frame.
// assumes: rx_frame_valid is a one-cycle pulse from a decoder on clk.
`timescale 1ns/100ps
module cswk_match
    import cswk_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    cswk_cfg_if.cmp          cfg,
    input  wire logic        rx_frame_valid,
    input  wire logic [28:0] rx_ident,
    input  wire logic        rx_rtr,
    input  wire logic        rx_ide
);

    logic [28:0] len_mask;
    logic [28:0] diff;
    logic        hit_d;
    logic        match_q;

    // standard frames carry only the upper eleven identifier bits
    assign len_mask = cfg.ide ? {29{1'b1}} : {{11{1'b1}}, {CSWK_STD_LSB{1'b0}}}; // [R15]
    assign diff     = (rx_ident ^ cfg.ident) & cfg.ident_cmp & len_mask; // [R18]
    assign hit_d    = cfg.enable & rx_frame_valid & (diff == 29'h0)
                    & (rx_rtr == cfg.rtr) & (rx_ide == cfg.ide); // [R19] [R4] [R14]

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            match_q <= 1'b0;
        else
            match_q <= hit_d;
    end

    assign cfg.match = match_q;

    a_match_needs_enable: assert property ( // [R4]
        @(posedge clk) disable iff (sys_rst) !cfg.enable |=> !cfg.match)
        else $error("wake match while selective wake disabled");

    a_match_needs_frame: assert property ( // [R19]
        @(posedge clk) disable iff (sys_rst) cfg.match |-> $past(rx_frame_valid))
        else $error("wake match without a received frame");

endmodule // cswk_match

// [core/cswk_core.sv]
// cswk_core: selective wake configuration registers, validity gating,
// oscillator trim gate and CAN time-out gating.
// assumes: the register port is driven by the serial decoder on clk, frame and
// time-out events come from logic on clk, the transmit pin is asynchronous.
//
// Functional notes
// [R1] trim field unlocks oscillator recalibration only when it holds 11
// [R2] unlocked active calibration uses the CAN transmit pin as reference
// [R3] host checks its configuration then writes 1 to the valid flag
// [R4] selective wake detection runs only while the valid flag is 1
// [R5] valid flag clears on wake-up, reset, or any configuration write
// [R6] time-out status bit updates only while selective wake mode is set
// [R7] time-out interrupt only with selective wake in Normal or Stop mode
// [R8] bit timing bits 15:10 hold the sample point fraction
// [R9] bit timing bits 7:0 hold time quanta per bit
// [R10] bit timing bits 9:8 and low identifier bit 7 read zero
// [R11] bit timing resets to CC96, restart clears only reserved bits
// [R12] high identifier register holds identifier bits 28 to 13
// [R13] low identifier holds bits 12..5 in 15..8, bits 4..0 in 6..2
// [R14] low identifier bit 1 selects expected RTR value
// [R15] low identifier bit 0 selects standard or extended identifier
// [R16] identifier registers reset to zero and keep contents on restart
// [R17] time-out mask bit 0 suppresses the interrupt, 1 passes it
// [R18] identifier mask bit 1 compares that bit, 0 ignores it
// [R19] enabled device compares received frames and signals wake on match
`timescale 1ns/100ps
module cswk_core
    import cswk_pkg::*;
#(
    parameter int SYNC_STAGES = 2
)(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        restart,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        can_transmit_input_pin,
    input  wire logic        wake_event,
    input  wire logic        can_mode_selective_wake,
    input  wire logic        mode_normal,
    input  wire logic        mode_stop,
    input  wire logic        can_timeout_event,
    input  wire logic        can_timeout_clr,
    input  wire logic        rx_frame_valid,
    input  wire logic [28:0] rx_ident,
    input  wire logic        rx_rtr,
    input  wire logic        rx_ide,
    output logic             selective_wake_enable,
    output logic             oscillator_calibration_enable,
    output logic             osc_sync_ref,
    output logic             can_timeout_flag,
    output logic             can_timeout_irq,
    output logic             wake_up_frame,
    output logic      [5:0]  sample_point_fraction,
    output logic      [7:0]  quanta_per_bit
);

    if (SYNC_STAGES < 2)
    begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] r);
        return a == r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [15:0] ctrl_q;
    logic        valid_q;
    logic        valid_d;
    logic [15:0] btim_q;
    logic [15:0] idh_q;
    logic [15:0] idl_q;
    logic [15:0] mskh_q;
    logic [15:0] mskl_q;
    logic [15:0] rdata_q;
    logic        osc_en_q;
    logic        ref_q;
    logic        to_flag_q;
    logic        to_flag_d;
    logic        irq_q;
    logic        irq_d;
    logic        to_set;
    logic        unlocked;

    logic        wr_ctrl;
    logic        wr_btim;
    logic        wr_idh;
    logic        wr_idl;
    logic        wr_mskh;
    logic        wr_mskl;
    logic        cfg_wr;
    logic        wake_any;
    logic [15:0] rd_mux;

    cswk_cfg_if cfg_bus ();

    ////////////////////////////////////////////////////////////////////////
    // address decode and read mux

    assign wr_ctrl = reg_wr & addr_hit(reg_addr, CSWK_ADDR_CTRL);
    assign wr_btim = reg_wr & addr_hit(reg_addr, CSWK_ADDR_BTIM);
    assign wr_idh  = reg_wr & addr_hit(reg_addr, CSWK_ADDR_IDH);
    assign wr_idl  = reg_wr & addr_hit(reg_addr, CSWK_ADDR_IDL);
    assign wr_mskh = reg_wr & addr_hit(reg_addr, CSWK_ADDR_MSKH);
    assign wr_mskl = reg_wr & addr_hit(reg_addr, CSWK_ADDR_MSKL);
    assign cfg_wr  = wr_btim | wr_idh | wr_idl | wr_mskh | wr_mskl;

    // unmapped addresses read as zero
    assign rd_mux =
        addr_hit(reg_addr, CSWK_ADDR_CTRL) ? (ctrl_q | {15'h0000, valid_q}) :
        addr_hit(reg_addr, CSWK_ADDR_BTIM) ? btim_q :
        addr_hit(reg_addr, CSWK_ADDR_IDH)  ? idh_q  :
        addr_hit(reg_addr, CSWK_ADDR_IDL)  ? idl_q  :
        addr_hit(reg_addr, CSWK_ADDR_MSKH) ? mskh_q :
        addr_hit(reg_addr, CSWK_ADDR_MSKL) ? mskl_q : 16'h0000;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            rdata_q <= 16'h0000;
        else if (reg_rd)
            rdata_q <= rd_mux;
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // control register and configuration-valid flag

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            ctrl_q <= CSWK_CTRL_RST;
        else if (wr_ctrl)
            ctrl_q <= reg_wdata & CSWK_CTRL_WMASK;
        else if (restart)
            ctrl_q <= ctrl_q & CSWK_CTRL_WMASK;
    end

    // a host write of 1 wins over a clear arriving in the same cycle
    assign wake_any = wake_event | cfg_bus.match; // [R5]
    assign valid_d  = wr_ctrl ? reg_wdata[CSWK_VALID_BIT] :       // [R3]
                      (cfg_wr | wake_any | restart) ? 1'b0 : valid_q; // [R5]

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            valid_q <= 1'b0; // [R5]
        else
            valid_q <= valid_d;
    end

    assign selective_wake_enable = valid_q; // [R4]

    ////////////////////////////////////////////////////////////////////////
    // configuration registers; reserved bits never store

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            btim_q <= CSWK_BTIM_RST; // [R11]
        else if (wr_btim)
            btim_q <= reg_wdata & CSWK_BTIM_WMASK; // [R10]
        else if (restart)
            btim_q <= btim_q & CSWK_BTIM_WMASK; // [R11]
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            idh_q <= CSWK_IDH_RST; // [R16]
        else if (wr_idh)
            idh_q <= reg_wdata; // [R12]
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            idl_q <= CSWK_IDL_RST; // [R16]
        else if (wr_idl)
            idl_q <= reg_wdata & CSWK_IDL_WMASK; // [R10]
        else if (restart)
            idl_q <= idl_q & CSWK_IDL_WMASK; // [R16]
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            mskh_q <= CSWK_MSKH_RST;
        else if (wr_mskh)
            mskh_q <= reg_wdata; // [R18]
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            mskl_q <= CSWK_MSKL_RST;
        else if (wr_mskl)
            mskl_q <= reg_wdata & CSWK_MSKL_WMASK; // [R18]
    end

    assign sample_point_fraction = btim_q[CSWK_SP_LSB +: 6]; // [R8]
    assign quanta_per_bit        = btim_q[CSWK_QPB_LSB +: 8]; // [R9]

    ////////////////////////////////////////////////////////////////////////
    // frame comparator

    assign cfg_bus.ident     = {idh_q, idl_q[15:8], idl_q[6:2]}; // [R12] [R13]
    assign cfg_bus.ident_cmp = {mskh_q, mskl_q[15:8], mskl_q[6:2]}; // [R18]
    assign cfg_bus.rtr       = idl_q[CSWK_RTR_BIT]; // [R14]
    assign cfg_bus.ide       = idl_q[CSWK_IDE_BIT]; // [R15]
    assign cfg_bus.enable    = valid_q; // [R4]

    cswk_match u_match (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .cfg            (cfg_bus.cmp),
        .rx_frame_valid (rx_frame_valid),
        .rx_ident       (rx_ident),
        .rx_rtr         (rx_rtr),
        .rx_ide         (rx_ide)
    );

    assign wake_up_frame = cfg_bus.match; // [R19]

    ////////////////////////////////////////////////////////////////////////
    // oscillator trim gate and transmit pin synchroniser

    logic [SYNC_STAGES-1:0] txd_sync_q;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            txd_sync_q[0] <= 1'b1;
        else
            txd_sync_q[0] <= can_transmit_input_pin;
    end

    for (genvar i = 1; i < SYNC_STAGES; i++)
    begin : g_sync
        always_ff @(posedge clk)
        begin
            if (sys_rst)
                txd_sync_q[i] <= 1'b1;
            else
                txd_sync_q[i] <= txd_sync_q[i-1];
        end
    end

    // any code other than the unlock pattern keeps trimming locked
    assign unlocked = ctrl_q[CSWK_TRIM_LSB +: 2] == CSWK_TRIM_OPEN; // [R1]

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            osc_en_q <= 1'b0;
            ref_q    <= 1'b0;
        end
        else
        begin
            osc_en_q <= ctrl_q[CSWK_OSC_BIT] & unlocked; // [R1]
            ref_q    <= osc_en_q & txd_sync_q[SYNC_STAGES-1]; // [R2]
        end
    end

    assign oscillator_calibration_enable = osc_en_q;
    assign osc_sync_ref                  = ref_q;

    ////////////////////////////////////////////////////////////////////////
    // CAN time-out status and interrupt gating

    assign to_set    = can_timeout_event & can_mode_selective_wake; // [R6]
    assign to_flag_d = to_set | (to_flag_q & ~can_timeout_clr);
    assign irq_d     = to_set & (mode_normal | mode_stop) // [R7]
                     & ctrl_q[CSWK_TOMASK_BIT]; // [R17]

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            to_flag_q <= 1'b0;
            irq_q     <= 1'b0;
        end
        else
        begin
            to_flag_q <= to_flag_d;
            irq_q     <= irq_d;
        end
    end

    assign can_timeout_flag = to_flag_q;
    assign can_timeout_irq  = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    a_trim_stays_locked: assert property ( // [R1]
        @(posedge clk) disable iff (sys_rst)
        ctrl_q[CSWK_TRIM_LSB +: 2] != CSWK_TRIM_OPEN |=> !oscillator_calibration_enable)
        else $error("calibration enabled with trim field locked");

    a_sync_ref_gated: assert property ( // [R2]
        @(posedge clk) disable iff (sys_rst)
        !oscillator_calibration_enable |=> !osc_sync_ref)
        else $error("sync reference passed while calibration inactive");

    a_config_write_clears: assert property ( // [R5]
        @(posedge clk) disable iff (sys_rst)
        cfg_wr |=> !selective_wake_enable)
        else $error("valid flag survived a configuration write");

    a_wake_clears_valid: assert property ( // [R5]
        @(posedge clk) disable iff (sys_rst)
        wake_up_frame && !wr_ctrl |=> !selective_wake_enable)
        else $error("valid flag survived a wake-up frame");

    a_valid_set_holds: assert property ( // [R4]
        @(posedge clk) disable iff (sys_rst)
        wr_ctrl && reg_wdata[CSWK_VALID_BIT] ##1
        !reg_wr && !wake_event && !wake_up_frame && !restart
        |-> selective_wake_enable)
        else $error("valid flag lost without a clearing cause");

    a_timeout_gated: assert property ( // [R6]
        @(posedge clk) disable iff (sys_rst)
        !can_timeout_flag && !can_mode_selective_wake |=> !can_timeout_flag)
        else $error("time-out flag set outside selective wake mode");

    a_irq_mode_gate: assert property ( // [R7]
        @(posedge clk) disable iff (sys_rst)
        can_timeout_irq |-> $past(can_mode_selective_wake)
        && $past(mode_normal || mode_stop) && can_timeout_flag)
        else $error("time-out interrupt outside allowed modes");

    a_irq_masked: assert property ( // [R17]
        @(posedge clk) disable iff (sys_rst)
        !ctrl_q[CSWK_TOMASK_BIT] ##1 !ctrl_q[CSWK_TOMASK_BIT] |=> !can_timeout_irq)
        else $error("masked time-out raised an interrupt");

    a_btim_reset_value: assert property ( // [R11]
        @(posedge clk)
        $past(sys_rst) |-> sample_point_fraction == 6'h33 && quanta_per_bit == 8'h96)
        else $error("bit timing reset value wrong");

    a_reserved_read_zero: assert property ( // [R10]
        @(posedge clk) disable iff (sys_rst)
        reg_rd && addr_hit(reg_addr, CSWK_ADDR_IDL) |=> reg_rdata[7] == 1'b0)
        else $error("reserved identifier bit read as one");

    a_idh_readback: assert property ( // [R12]
        @(posedge clk) disable iff (sys_rst)
        wr_idh ##1 !reg_wr ##1 (reg_rd && !reg_wr && addr_hit(reg_addr, CSWK_ADDR_IDH))
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("high identifier readback mismatch");

endmodule // cswk_core

// [tb/cswk_host_model.sv]
// cswk_host_model: host side of the register port, issuing writes and reads.
// assumes: one clock shared with the device; read expectations are queued
// here and checked by the bench monitor.
`timescale 1ns/100ps
module cswk_host_model
    import cswk_pkg::*;
(
    input  wire logic        clk,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [6:0]  reg_addr,
    output logic      [15:0] reg_wdata
);
    logic [15:0] exp_q[$];

    initial
    begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 7'h00;
        reg_wdata = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // released data lines flip so a stale value is never mistaken for data
    // one idle edge after each strobe, so a following call never raises
    // a strobe in the same time step in which this one dropped it
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        @(posedge clk);
        #1;
    endtask

    // write, read back, then mark the configuration valid
    task automatic cfg(input logic [15:0] idh, input logic [15:0] idl,
                       input logic [15:0] ctrl);
        wr(CSWK_ADDR_IDH, idh);
        rd(CSWK_ADDR_IDH, idh);
        wr(CSWK_ADDR_IDL, idl);
        rd(CSWK_ADDR_IDL, idl & CSWK_IDL_WMASK);
        wr(CSWK_ADDR_CTRL, ctrl | 16'h0001);
    endtask
endmodule // cswk_host_model

// [tb/cswk_core_tb_top.sv]
// cswk_core_tb_top: self-checking bench of the selective wake block.
// assumes: host model drives the register port; frames, modes and time-outs
// come from this bench one step after the rising edge.
`timescale 1ns/100ps
module cswk_core_tb_top
    import cswk_pkg::*;
;
    logic        clk, sys_rst, restart, reg_wr, reg_rd, pin, wake_event;
    logic        mode_sw, mode_normal, mode_stop, to_ev, to_clr;
    logic        rx_v, rx_rtr, rx_ide, sw_en, osc_en, osc_ref, to_flag, to_irq, wake;
    logic [6:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, err_total, total_checks, n_wake, n_irq;
    logic [15:0] idh, idl, cycles;
    logic [28:0] rx_id, id;
    logic [5:0]  sp;
    logic [7:0]  qpb;

    cswk_core #(.SYNC_STAGES(2)) cswk_core_i (
        .clk(clk), .sys_rst(sys_rst), .restart(restart), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .can_transmit_input_pin(pin),
        .wake_event(wake_event), .can_mode_selective_wake(mode_sw),
        .mode_normal(mode_normal), .mode_stop(mode_stop),
        .can_timeout_event(to_ev), .can_timeout_clr(to_clr),
        .rx_frame_valid(rx_v), .rx_ident(rx_id), .rx_rtr(rx_rtr), .rx_ide(rx_ide),
        .selective_wake_enable(sw_en), .oscillator_calibration_enable(osc_en),
        .osc_sync_ref(osc_ref), .can_timeout_flag(to_flag),
        .can_timeout_irq(to_irq), .wake_up_frame(wake),
        .sample_point_fraction(sp), .quanta_per_bit(qpb));

    cswk_host_model cswk_host_model_i (
        .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));

    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks = total_checks + 16'h0001;
        if (got !== exp)
        begin
            err_total = err_total + 16'h0001;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 16'h0000 && total_checks != 16'h0000)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // read results appear one edge after the strobe; oldest note first
    always @(posedge clk)
    begin
        cycles = cycles + 16'h0001;
        if (wake === 1'b1)
            n_wake = n_wake + 16'h0001;
        if (to_irq === 1'b1)
            n_irq = n_irq + 16'h0001;
        if (cycles == 16'd6000)
        begin
            err_total = err_total + 16'h0001;
            finish_test();
        end
        if (reg_rd === 1'b1 && sys_rst === 1'b0)
        begin
            #2;
            chk(reg_rdata, cswk_host_model_i.exp_q.pop_front());
        end
    end

    task automatic frame(input logic [28:0] i, input logic r, input logic e,
                         input logic [15:0] exp_wake);
        rx_id  = i;
        rx_rtr = r;
        rx_ide = e;
        rx_v   = 1'b1;
        cyc(1);
        rx_v   = 1'b0;
        rx_id  = ~i;
        cyc(3);
        chk(n_wake, exp_wake);
    endtask

    task automatic tmo(input logic [15:0] exp_irq, input logic exp_flag);
        to_ev = 1'b1;
        cyc(1);
        to_ev = 1'b0;
        cyc(2);
        chk(n_irq, exp_irq);
        chk({15'h0, to_flag}, {15'h0, exp_flag});
        to_clr = 1'b1;
        cyc(1);
        to_clr = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {clk, restart, pin, wake_event, mode_sw, mode_normal, mode_stop} = '0;
        {to_ev, to_clr, rx_v, rx_rtr, rx_ide, rx_id} = '0;
        {err_total, total_checks, n_wake, n_irq, cycles} = '0;
        sys_rst = 1'b1;
        void'($urandom(32'h0870));
        cyc(20);
        sys_rst = 1'b0;
        chk({10'h0, sp}, 16'h0033);
        chk({8'h0, qpb}, 16'h0096);
        cswk_host_model_i.rd(CSWK_ADDR_BTIM, 16'hCC96);
        cswk_host_model_i.rd(CSWK_ADDR_IDL, 16'h0000);
        cswk_host_model_i.wr(CSWK_ADDR_BTIM, 16'hFFFF);
        cswk_host_model_i.rd(CSWK_ADDR_BTIM, 16'hFCFF);
        chk({10'h0, sp}, 16'h003F);
        chk({8'h0, qpb}, 16'h00FF);
        idh = 16'($urandom);
        cswk_host_model_i.wr(CSWK_ADDR_BTIM, idh);
        cswk_host_model_i.wr(CSWK_ADDR_IDL, 16'hFFFF);
        restart = 1'b1;
        cyc(1);
        restart = 1'b0;
        cswk_host_model_i.rd(CSWK_ADDR_BTIM, idh & 16'hFCFF);
        cswk_host_model_i.rd(CSWK_ADDR_IDL, 16'hFF7F);
        cswk_host_model_i.rd(7'h7F, 16'h0000);
        // system reset in mid-run must bring back the documented values
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        cswk_host_model_i.rd(CSWK_ADDR_IDL, 16'h0000);
        cswk_host_model_i.rd(CSWK_ADDR_BTIM, 16'hCC96);
        $display("register test done");
        cswk_host_model_i.wr(CSWK_ADDR_MSKH, 16'hFFFF);
        cswk_host_model_i.wr(CSWK_ADDR_MSKL, 16'hFF7C);
        for (int k = 0; k < 4; k++)
        begin
            idh = 16'($urandom);
            idl = (16'($urandom) & 16'hFF7C) | 16'(k);
            id  = {idh, idl[15:8], idl[6:2]};
            frame(id, idl[1], idl[0], n_wake);
            cswk_host_model_i.cfg(idh, idl, 16'h0000);
            cyc(1);
            chk({15'h0, sw_en}, 16'h0001);
            frame(id, ~idl[1], idl[0], n_wake);
            frame(id, idl[1], ~idl[0], n_wake);
            frame(id ^ 29'h0004_0000, idl[1], idl[0], n_wake);
            frame(id, idl[1], idl[0], n_wake + 16'h0001);
            chk({15'h0, sw_en}, 16'h0000);
        end
        // a cleared compare bit must let a differing identifier bit through
        cswk_host_model_i.wr(CSWK_ADDR_MSKH, 16'h0000);
        cswk_host_model_i.cfg(idh, idl, 16'h0000);
        frame(id ^ 29'h1000_0000, idl[1], idl[0], n_wake + 16'h0001);
        cswk_host_model_i.cfg(idh, idl, 16'h0000);
        wake_event = 1'b1;
        cyc(1);
        wake_event = 1'b0;
        cyc(2);
        chk({15'h0, sw_en}, 16'h0000);
        cswk_host_model_i.cfg(idh, idl, 16'h0000);
        cswk_host_model_i.wr(CSWK_ADDR_MSKL, 16'hFF7C);
        cyc(2);
        chk({15'h0, sw_en}, 16'h0000);
        cswk_host_model_i.rd(CSWK_ADDR_IDH, idh);
        $display("frame test done");
        cswk_host_model_i.wr(CSWK_ADDR_CTRL, 16'h0010);
        tmo(n_irq, 1'b0);
        mode_sw     = 1'b1;
        mode_normal = 1'b1;
        tmo(n_irq + 16'h0001, 1'b1);
        mode_normal = 1'b0;
        tmo(n_irq, 1'b1);
        mode_stop   = 1'b1;
        tmo(n_irq + 16'h0001, 1'b1);
        cswk_host_model_i.wr(CSWK_ADDR_CTRL, 16'h0000);
        tmo(n_irq, 1'b1);
        $display("time-out test done");
        for (int t = 0; t < 4; t++)
        begin
            cswk_host_model_i.wr(CSWK_ADDR_CTRL, 16'h0080 | 16'(t << 5));
            cyc(2);
            chk({15'h0, osc_en}, (t == 3) ? 16'h0001 : 16'h0000);
        end
        pin = 1'b1;
        cyc(6);
        chk({15'h0, osc_ref}, 16'h0001);
        pin = 1'b0;
        cyc(6);
        chk({15'h0, osc_ref}, 16'h0000);
        $display("oscillator test done");
        finish_test();
    end
endmodule // cswk_core_tb_top
